/* hdl/cit_core.sv */
// instruction sequencer with per-class cycle timing and external moves
`timescale 1ns/10ps
`include "cit_defs.svh"
module cit_core
	import cit_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// program memory, one byte per cycle, combinational read
	output logic [15:0] pc_addr,
	input wire logic [7:0] code_byte,
	// external move port
	output cit_pkg::cit_xmem_s external_data_ram_port,
	output cit_pkg::cit_xmem_s xext_port,
	output cit_pkg::cit_xmem_s flash_port,
	input wire logic [7:0] xmem_rdata,
	// visible state
	output logic [7:0] acc_out,
	output logic [7:0] flags_out,
	output logic instr_done
);
	////////////////////////////////////////////////////////////////////
	// state
	cit_state_e state_reg, state_next;
	logic [15:0] pc_reg; // fetch address
	logic [7:0] op_reg; // current opcode
	logic [7:0] b1_reg, b2_reg; // operand bytes
	logic [3:0] cnt_reg; // cycle within instruction
	cit_plan_s plan_reg;
	logic [7:0] acc_reg, b_reg, flags_reg, dpl_reg, dph_reg;
	logic [7:0] iram [0:255]; // internal data ram and direct space
	logic [7:0] rbank [0:7]; // working registers
	cit_xmem_s external_data_ram_reg, xext_reg, flash_reg;
	logic done_reg;
	logic flash_wen_reg; // software flash write enable bit
	////////////////////////////////////////////////////////////////////
	// decode: length and cycle count from opcode
	wire [3:0] lo = code_byte[3:0];
	wire [3:0] hi = code_byte[7:4];
	wire is_rn = code_byte[3];
	wire is_ind = (lo == 4'h6) || (lo == 4'h7);
	wire is_dir = (lo == 4'h5);
	wire is_imm = (lo == 4'h4);
	wire is_alu = (hi == 4'h2) || (hi == 4'h3) || (hi == 4'h9) ||
		(hi == 4'h5) || (hi == 4'h4) || (hi == 4'h6);
	wire is_mul = (code_byte == 8'ha4);
	wire is_div = (code_byte == 8'h84);
	wire is_incdec = (hi == 4'h0) || (hi == 4'h1);
	wire is_lg_dir_a = ((hi == 4'h4) || (hi == 4'h5) || (hi == 4'h6)) &&
		(lo == 4'h2);
	wire is_lg_dir_i = ((hi == 4'h4) || (hi == 4'h5) || (hi == 4'h6)) &&
		(lo == 4'h3);
	wire is_jz = (code_byte == 8'h60) || (code_byte == 8'h70);
	wire is_external_move_instr = (hi == 4'he || hi == 4'hf) && (lo == 4'h0);
	wire is_incdp = (code_byte == 8'ha3);
	// plain moves: length decides timing, one cycle per program byte
	wire is_mov2 = (code_byte == 8'h74) || (code_byte == 8'he5) ||
		(code_byte == 8'hf5) || (hi == 4'h7 && is_rn);
	wire is_mov3 = (code_byte == 8'h75) || (code_byte == 8'h90);
	cit_plan_s dec_plan;
	assign dec_plan =
		is_mul ? '{4'h1, `CIT_MUL_CYC} :
		is_div ? '{4'h1, `CIT_DIV_CYC} :
		is_lg_dir_i ? '{4'h3, 4'h3} :
		is_lg_dir_a ? '{4'h2, 4'h2} :
		is_jz ? '{4'h2, 4'h3} :
		is_external_move_instr ? '{4'h1, 4'h2} :
		is_incdp ? '{4'h1, 4'h1} :
		is_mov3 ? '{4'h3, 4'h3} :
		is_mov2 ? '{4'h2, 4'h2} :
		(is_alu || is_incdec) && is_rn ? '{4'h1, 4'h1} :
		(is_alu || is_incdec) && is_ind ? '{4'h1, 4'h2} :
		((is_alu || is_incdec) && is_dir) || (is_alu && is_imm) ?
		'{4'h2, 4'h2} :
		'{4'h1, 4'h1};
	////////////////////////////////////////////////////////////////////
	// operand selection and arithmetic with standard flag effects
	wire [2:0] rsel = op_reg[2:0];
	wire [7:0] ind_v = iram[rbank[{2'b00, op_reg[0]}]];
	wire [7:0] src_v = op_reg[3] ? rbank[rsel] :
		(op_reg[3:0] == 4'h4) ? b1_reg :
		(op_reg[3:0] == 4'h5) ? iram[b1_reg] : ind_v;
	wire cy_in = (op_reg[7:4] == 4'h2) ? 1'b0 : flags_reg[`CIT_FLAG_CY];
	wire is_sub = (op_reg[7:4] == 4'h9);
	wire [7:0] opnd = is_sub ? ~src_v : src_v;
	wire cin = is_sub ? ~cy_in : cy_in;
	wire [8:0] sum = {1'b0, acc_reg} + {1'b0, opnd} + {8'h00, cin};
	wire [4:0] hsum = {1'b0, acc_reg[3:0]} + {1'b0, opnd[3:0]} +
		{4'h0, cin};
	wire ov = (acc_reg[7] == opnd[7]) && (sum[7] != acc_reg[7]);
	wire [15:0] prod = acc_reg * b_reg;
	wire [7:0] quo = (b_reg == 8'h00) ? 8'hff : acc_reg / b_reg;
	wire [7:0] rem = (b_reg == 8'h00) ? 8'h00 : acc_reg % b_reg;
	wire [15:0] data_pointer = {dph_reg, dpl_reg};
	wire [15:0] data_pointer_inc = data_pointer + 16'h0001;
	// direct read: the few core registers, else iram at the full direct address
	wire [7:0] dir_rd = (b1_reg == `CIT_SFR_B) ? b_reg :
		(b1_reg == `CIT_SFR_DPL) ? dpl_reg :
		(b1_reg == `CIT_SFR_DPH) ? dph_reg : iram[b1_reg];
	wire br_take = (op_reg == 8'h60) ? (acc_reg == 8'h00) :
		(acc_reg != 8'h00);
	wire [15:0] br_tgt = pc_reg + {{8{b1_reg[7]}}, b1_reg};
	// external_move_instr target: flash when writes enabled, on-chip below limit
	wire [15:0] xaddr = data_pointer;
	wire tgt_flash = flash_wen_reg;
	wire tgt_int = !tgt_flash && (xaddr < `CIT_EXTERNAL_DATA_RAM_ONCHIP);
	wire tgt_ext = !tgt_flash && !tgt_int;
	wire [3:0] cnt_inc = cnt_reg + 4'h1;
	// the fetch cycle is cycle one, so cnt_reg + 2 is the cycle now ending
	wire last_cyc = (cnt_inc + 4'h1 >= plan_reg.cyc) ||
		(op_reg[7:5] == 3'b011 && op_reg[3:0] == 4'h0 &&
		!br_take && cnt_inc + 4'h1 >= 4'h2);
	////////////////////////////////////////////////////////////////////
	// sequencer next state: fetch, operand bytes, wait; CIT_EXEC is never entered
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			CIT_FETCH: state_next = (dec_plan.len > 4'h1) ? CIT_OPER :
				(dec_plan.cyc > 4'h1) ? CIT_WAIT : CIT_FETCH;
			CIT_OPER: state_next = (cnt_inc + 4'h1 < plan_reg.len) ?
				CIT_OPER : (last_cyc ? CIT_FETCH : CIT_WAIT);
			CIT_WAIT: state_next = last_cyc ? CIT_FETCH : CIT_WAIT;
			default: state_next = CIT_FETCH;
		endcase
	end
	////////////////////////////////////////////////////////////////////
	// sequencer registers; one count step per clock, no machine cycle
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			state_reg <= CIT_FETCH;
			pc_reg <= 16'h0000;
			cnt_reg <= 4'h0;
			op_reg <= `CIT_RST_BYTE;
			b1_reg <= `CIT_RST_BYTE;
			b2_reg <= `CIT_RST_BYTE;
			plan_reg <= '{4'h1, 4'h1};
			done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			done_reg <= 1'b0;
			case (state_reg)
				CIT_FETCH:
				begin
					op_reg <= code_byte;
					plan_reg <= dec_plan;
					pc_reg <= pc_reg + 16'h0001;
					cnt_reg <= 4'h0;
					done_reg <= (state_next == CIT_FETCH);
				end
				CIT_OPER:
				begin
					if (cnt_reg == 4'h0)
						b1_reg <= code_byte;
					else
						b2_reg <= code_byte;
					pc_reg <= pc_reg + 16'h0001;
					cnt_reg <= cnt_inc;
					done_reg <= (state_next == CIT_FETCH);
				end
				CIT_WAIT:
				begin
					cnt_reg <= cnt_inc;
					if (last_cyc && op_reg[7:5] == 3'b011 &&
						op_reg[3:0] == 4'h0 && br_take)
						pc_reg <= br_tgt;
					done_reg <= last_cyc;
				end
				default: cnt_reg <= 4'h0;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////
	// execute: architectural update in the cycle after the final one, while done_reg is high
	wire exec_now = done_reg;
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			acc_reg <= `CIT_RST_BYTE;
			b_reg <= `CIT_RST_BYTE;
			flags_reg <= `CIT_RST_BYTE;
			dpl_reg <= `CIT_RST_BYTE;
			dph_reg <= `CIT_RST_BYTE;
			flash_wen_reg <= 1'b0;
		end
		else if (exec_now)
		begin
			case (op_reg[7:4])
				4'h2, 4'h3, 4'h9:
				if (op_reg[3:0] >= 4'h4)
				begin
					acc_reg <= sum[7:0];
					flags_reg[`CIT_FLAG_CY] <= is_sub ? ~sum[8] : sum[8];
					flags_reg[`CIT_FLAG_AC] <= is_sub ? ~hsum[4] : hsum[4];
					flags_reg[`CIT_FLAG_OV] <= ov;
				end
				else if (op_reg == 8'h90)
				begin
					dph_reg <= b1_reg;
					dpl_reg <= b2_reg;
				end
				4'h7: if (op_reg == 8'h74) acc_reg <= b1_reg;
				4'h5: if (op_reg[3:0] >= 4'h4) acc_reg <= acc_reg & src_v;
				4'h4: if (op_reg[3:0] >= 4'h4) acc_reg <= acc_reg | src_v;
				4'h6: if (op_reg[3:0] >= 4'h4) acc_reg <= acc_reg ^ src_v;
				4'h0: if (op_reg == 8'h04) acc_reg <= acc_reg + 8'h01;
				4'h1: if (op_reg == 8'h14) acc_reg <= acc_reg - 8'h01;
				4'ha:
				if (op_reg == 8'ha4)
				begin
					acc_reg <= prod[7:0];
					b_reg <= prod[15:8];
					flags_reg[`CIT_FLAG_CY] <= 1'b0;
					flags_reg[`CIT_FLAG_OV] <= (prod[15:8] != 8'h00);
				end
				else if (op_reg == 8'ha3)
				begin
					dpl_reg <= data_pointer_inc[7:0];
					dph_reg <= data_pointer_inc[15:8];
				end
				4'h8:
				if (op_reg == 8'h84)
				begin
					acc_reg <= quo;
					b_reg <= rem;
					flags_reg[`CIT_FLAG_CY] <= 1'b0;
					flags_reg[`CIT_FLAG_OV] <= (b_reg == 8'h00);
				end
				4'he:
				if (op_reg == 8'he0)
					acc_reg <= xmem_rdata;
				else if (op_reg == 8'he5)
					acc_reg <= dir_rd;
				default: flags_reg <= flags_reg;
			endcase
			if (op_reg == 8'hf5 && b1_reg == 8'hb7)
				flash_wen_reg <= acc_reg[0];
			if (op_reg == 8'hf5 && b1_reg == `CIT_SFR_B)
				b_reg <= acc_reg;
			if (op_reg == 8'hf5 && b1_reg == `CIT_SFR_DPL)
				dpl_reg <= acc_reg;
			if (op_reg == 8'hf5 && b1_reg == `CIT_SFR_DPH)
				dph_reg <= acc_reg;
		end
	end
	////////////////////////////////////////////////////////////////////
	// working registers and direct/indirect space
	wire is_rn_w = (op_reg[7:5] == 3'b000) && op_reg[3];
	wire mov_rn_i = (op_reg[7:4] == 4'h7) && op_reg[3]; // immediate to rn
	wire mov_rn_a = (op_reg[7:4] == 4'hf) && op_reg[3]; // acc to rn
	wire mov_dir_i = (op_reg == 8'h75); // immediate to direct
	wire mov_dir_a = (op_reg == 8'hf5) && !b1_reg[7]; // ram half only
	wire is_lgd = (op_reg[7:4] >= 4'h4 && op_reg[7:4] <= 4'h6) &&
		(op_reg[3:1] == 3'b001);
	wire dir_w = (op_reg[7:4] <= 4'h1 && (op_reg[3:0] == 4'h5 ||
		op_reg[3:1] == 3'b011)) || is_lgd;
	wire [7:0] dir_a = (op_reg[3:1] == 3'b011 && !is_lgd) ?
		rbank[{2'b00, op_reg[0]}] : b1_reg;
	wire [7:0] dv = (op_reg[3:1] == 3'b011 && !is_lgd) ? ind_v :
		op_reg[3] ? rbank[rsel] : iram[b1_reg];
	wire [7:0] lg_src = op_reg[0] ? b2_reg : acc_reg;
	wire [7:0] wr_v = is_lgd ? ((op_reg[7:4] == 4'h5) ? dv & lg_src :
		(op_reg[7:4] == 4'h4) ? dv | lg_src : dv ^ lg_src) :
		op_reg[4] ? dv - 8'h01 : dv + 8'h01;
	wire [7:0] rn_v = mov_rn_i ? b1_reg : mov_rn_a ? acc_reg : wr_v;
	wire [7:0] dir_v = mov_dir_i ? b2_reg : mov_dir_a ? acc_reg : wr_v;
	// storage has no reset; software sets what it reads
	always_ff @(posedge clk_sys)
	begin
		if (exec_now && (is_rn_w || mov_rn_i || mov_rn_a))
			rbank[rsel] <= rn_v;
		if (exec_now && (dir_w || mov_dir_i || mov_dir_a))
			iram[dir_a] <= dir_v;
	end
	////////////////////////////////////////////////////////////////////
	// external move request, issued in the execute wait cycle
	wire xreq = (state_reg == CIT_WAIT) && (op_reg[7:5] == 3'b111) &&
		(op_reg[3:0] == 4'h0);
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			external_data_ram_reg <= '0;
			xext_reg <= '0;
			flash_reg <= '0;
		end
		else
		begin
			external_data_ram_reg <= '{xreq && tgt_int, op_reg[4], xaddr, acc_reg};
			xext_reg <= '{xreq && tgt_ext, op_reg[4], xaddr, acc_reg};
			flash_reg <= '{xreq && tgt_flash, op_reg[4], xaddr, acc_reg};
		end
	end
	////////////////////////////////////////////////////////////////////
	// outputs from flip-flops, except flag bit 0, the parity of acc_reg
	always_comb
	begin
		pc_addr = pc_reg;
		external_data_ram_port = external_data_ram_reg;
		xext_port = xext_reg;
		flash_port = flash_reg;
		acc_out = acc_reg;
		flags_out = {flags_reg[7:1], ^acc_reg};
		instr_done = done_reg;
	end
	////////////////////////////////////////////////////////////////////
	// checks
	sequence s_mul_start;
		state_reg == CIT_FETCH && code_byte == 8'ha4;
	endsequence
	chk_mul_four: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_mul_start |=> !instr_done [*3] ##1 instr_done)
		else $error("multiply not four cycles");
	chk_div_eight: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == CIT_FETCH && code_byte == 8'h84 |=>
		!instr_done [*7] ##1 instr_done)
		else $error("divide not eight cycles");
	chk_add_carry_instr_one: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == CIT_FETCH && code_byte[7:3] == 5'b00111 |=>
		instr_done && pc_reg == $past(pc_reg) + 16'h0001)
		else $error("add carry register not one cycle");
	chk_lgdir_three: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == CIT_FETCH && is_lg_dir_i |=>
		!instr_done [*2] ##1 instr_done)
		else $error("logic immediate to direct not three cycles");
	chk_stall_fetch: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == CIT_WAIT |=> $stable(pc_reg) || instr_done)
		else $error("fetch moved during stall");
	chk_max_cycles: assert property (@(posedge clk_sys) disable iff (!nrst)
		cnt_reg <= `CIT_MAX_CYC)
		else $error("instruction beyond eight cycles");
	chk_ind_two: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == CIT_FETCH && is_alu && is_ind |=>
		!instr_done ##1 instr_done)
		else $error("indirect operand not two cycles");
	chk_external_move_instr_route: assert property (@(posedge clk_sys) disable iff (!nrst)
		xreq && tgt_ext |=> xext_port.req && !external_data_ram_port.req)
		else $error("off-chip move misrouted");
endmodule

/* hdl/cit_defs.svh */
// constants for the instruction timing core: offsets, encodings, counts
`ifndef CIT_DEFS_SVH
`define CIT_DEFS_SVH
`define CIT_SFR_DPL 8'h82
`define CIT_SFR_DPH 8'h83
`define CIT_SFR_B 8'hf0
`define CIT_SFR_ACC 8'he0
`define CIT_SFR_FLAGS 8'hd0
`define CIT_RST_BYTE 8'h00
`define CIT_RST_SP 8'h07
`define CIT_MUL_CYC 4'h4
`define CIT_DIV_CYC 4'h8
`define CIT_MAX_CYC 4'h8
`define CIT_EXTERNAL_DATA_RAM_ONCHIP 16'h1000
`define CIT_FLAG_CY 7
`define CIT_FLAG_AC 6
`define CIT_FLAG_OV 2
`define CIT_FLAG_P 0
`endif

/* hdl/cit_pkg.sv */
// types for the instruction timing core
package cit_pkg;
	// decoded execution plan of one instruction
	typedef struct packed {
		logic [3:0] len;
		logic [3:0] cyc;
	} cit_plan_s;
	// external move request toward memories
	typedef struct packed {
		logic req;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cit_xmem_s;
	typedef enum logic [3:0] {
		CIT_FETCH = 4'b0001,
		CIT_OPER = 4'b0010,
		CIT_EXEC = 4'b0100,
		CIT_WAIT = 4'b1000
	} cit_state_e;
endpackage

/* verification/cit_mem_model.sv */
// program memory and external data memory model facing the core
`timescale 1ns/10ps
module cit_mem_model
	import cit_pkg::*;
(
	// clock
	clk_sys,
	// fetch side
	pc_addr,
	code_byte,
	// external move side
	external_data_ram_port,
	xext_port,
	flash_port,
	xmem_rdata
);
	input wire logic clk_sys;
	input wire logic [15:0] pc_addr;
	output logic [7:0] code_byte;
	input wire cit_pkg::cit_xmem_s external_data_ram_port;
	input wire cit_pkg::cit_xmem_s xext_port;
	input wire cit_pkg::cit_xmem_s flash_port;
	output logic [7:0] xmem_rdata;
	logic [7:0] code [0:65535]; // program image, loaded by the bench
	logic [7:0] dmem [3][0:65535]; // on-chip ram, off-chip ram, flash
	int rd_cnt [3]; // reads seen per target
	int wr_cnt [3]; // writes seen per target
	cit_xmem_s prt [3]; // the three targets side by side
	assign code_byte = code[pc_addr];
	assign prt[0] = external_data_ram_port;
	assign prt[1] = xext_port;
	assign prt[2] = flash_port;
	initial xmem_rdata = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// read data only valid the cycle after a request; otherwise it toggles
	// so a late sample by the core never sees stale data
	always @(negedge clk_sys)
	begin
		xmem_rdata <= ~xmem_rdata;
		for (int i = 0; i < 3; i++)
			if (prt[i].req === 1'b1)
			begin
				if (prt[i].wr)
				begin
					dmem[i][prt[i].addr] <= prt[i].wdata;
					wr_cnt[i]++;
				end
				else
				begin
					xmem_rdata <= dmem[i][prt[i].addr];
					rd_cnt[i]++;
				end
			end
	end
endmodule

/* verification/test_cit_core.sv */
// self-checking bench: timing and results of a short instruction program
`timescale 1ns/10ps
module test_cit_core;
	import cit_pkg::*;
	typedef struct {logic [23:0] b; int n; int c; int k; logic [7:0] a;
		logic [7:0] f;} cit_step_s;
	logic clk_sys;
	logic nrst;
	logic [15:0] pc_addr;
	logic [7:0] code_byte;
	cit_xmem_s external_data_ram_port;
	cit_xmem_s xext_port;
	cit_xmem_s flash_port;
	logic [7:0] xmem_rdata;
	logic [7:0] acc_out;
	logic [7:0] flags_out;
	logic instr_done;
	int error_cnt;
	int samples_checked;
	int cyc_cnt;
	int load_pc;
	int gap;
	cit_step_s prog [$]; // expected timing and results, in program order
	cit_core uut (.clk_sys(clk_sys), .nrst(nrst), .pc_addr(pc_addr),
		.code_byte(code_byte), .external_data_ram_port(external_data_ram_port), .xext_port(xext_port),
		.flash_port(flash_port), .xmem_rdata(xmem_rdata), .acc_out(acc_out),
		.flags_out(flags_out), .instr_done(instr_done));
	cit_mem_model mem (.clk_sys(clk_sys), .pc_addr(pc_addr),
		.code_byte(code_byte), .external_data_ram_port(external_data_ram_port), .xext_port(xext_port),
		.flash_port(flash_port), .xmem_rdata(xmem_rdata));
	////////////////////////////////////////////////////////////////////////
	// place one instruction in program memory and note what it should do
	function void step(input logic [23:0] b, input int n, c, k,
		input logic [7:0] a, f);
		cit_step_s s;
		s = '{b, n, c, k, a, f};
		prog.push_back(s);
		for (int i = 0; i < n; i++)
			mem.code[16'(load_pc + i)] = b[23 - 8 * i -: 8];
		load_pc += n;
	endfunction
	task check(input string nm, input logic [15:0] exp, got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// cycles from the previous completion pulse, bounded against a hang
	task wait_done(output int g);
		g = 0;
		do
		begin
			@(negedge clk_sys);
			g++;
		end
		while (instr_done !== 1'b1 && g < 20);
	endtask
	// results land on the edge that closes the completion cycle
	task check_res(input int j);
		if (prog[j].k > 0)
			check("acc", {8'h00, prog[j].a}, {8'h00, acc_out});
		if (prog[j].k > 1)
			check("flags", {8'h00, prog[j].f}, {8'h00, flags_out});
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// the program needs about a hundred cycles; this ceiling is generous
	always @(posedge clk_sys)
	begin
		cyc_cnt++;
		if (cyc_cnt == 3000)
		begin
			error_cnt++;
			$display("CHECK FAILED watchdog expected done seen hang");
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		nrst = 1'b0;
		error_cnt = 0;
		samples_checked = 0;
		cyc_cnt = 0;
		load_pc = 0;
		for (int i = 0; i < 65536; i++)
			mem.code[i] = 8'h00;
		mem.dmem[0][16'h0040] = 8'h5a;
		step(24'h743500, 2, 2, 1, 8'h35, 8'h00);
		step(24'h241000, 2, 2, 2, 8'h45, 8'h01);
		step(24'h440a00, 2, 2, 1, 8'h4f, 8'h00);
		step(24'h54f000, 2, 2, 1, 8'h40, 8'h00);
		step(24'h64ff00, 2, 2, 1, 8'hbf, 8'h00);
		step(24'h344100, 2, 2, 2, 8'h00, 8'hc0);
		step(24'h944000, 2, 2, 2, 8'hbf, 8'hc1);
		step(24'hf5f000, 2, 2, 0, 8'h00, 8'h00);
		step(24'h740300, 2, 2, 1, 8'h03, 8'h00);
		step(24'ha40000, 1, 4, 2, 8'h3d, 8'h45);
		step(24'h740900, 2, 2, 1, 8'h09, 8'h00);
		step(24'h840000, 1, 8, 2, 8'h04, 8'h41);
		step(24'hf80000, 1, 1, 0, 8'h00, 8'h00);
		step(24'h280000, 1, 1, 2, 8'h08, 8'h01);
		step(24'h380000, 1, 1, 1, 8'h0c, 8'h00);
		step(24'h580000, 1, 1, 1, 8'h04, 8'h00);
		step(24'h480000, 1, 1, 1, 8'h04, 8'h00);
		step(24'h680000, 1, 1, 1, 8'h00, 8'h00);
		step(24'h600000, 2, 3, 0, 8'h00, 8'h00);
		step(24'h700000, 2, 2, 0, 8'h00, 8'h00);
		step(24'h040000, 1, 1, 1, 8'h01, 8'h00);
		step(24'h140000, 1, 1, 1, 8'h00, 8'h00);
		step(24'h783000, 2, 2, 0, 8'h00, 8'h00);
		step(24'h753007, 3, 3, 0, 8'h00, 8'h00);
		step(24'h260000, 1, 2, 1, 8'h07, 8'h00);
		step(24'h253000, 2, 2, 1, 8'h0e, 8'h00);
		step(24'h533003, 3, 3, 0, 8'h00, 8'h00);
		step(24'h423000, 2, 2, 0, 8'h00, 8'h00);
		step(24'h6330f0, 3, 3, 0, 8'h00, 8'h00);
		step(24'he53000, 2, 2, 1, 8'hff, 8'h00);
		step(24'h053000, 2, 2, 0, 8'h00, 8'h00);
		step(24'h160000, 1, 2, 0, 8'h00, 8'h00);
		step(24'he53000, 2, 2, 1, 8'hff, 8'h00);
		step(24'h900040, 3, 3, 0, 8'h00, 8'h00);
		step(24'he00000, 1, 2, 1, 8'h5a, 8'h00);
		step(24'h902000, 3, 3, 0, 8'h00, 8'h00);
		step(24'hf00000, 1, 2, 0, 8'h00, 8'h00);
		step(24'h740000, 2, 2, 1, 8'h00, 8'h00);
		step(24'he00000, 1, 2, 1, 8'h5a, 8'h00);
		step(24'h740100, 2, 2, 1, 8'h01, 8'h00);
		step(24'hf5b700, 2, 2, 0, 8'h00, 8'h00);
		step(24'h900300, 3, 3, 0, 8'h00, 8'h00);
		step(24'hf00000, 1, 2, 0, 8'h00, 8'h00);
		mem.code[16'(load_pc)] = 8'h80;
		mem.code[16'(load_pc + 1)] = 8'hfe;
		repeat (8) @(negedge clk_sys);
		check("acc at reset", 16'h0000, {8'h00, acc_out});
		check("flags at reset", 16'h0000, {8'h00, flags_out});
		check("pc at reset", 16'h0000, pc_addr);
		nrst = 1'b1;
		foreach (prog[i])
		begin
			wait_done(gap);
			if (i > 0)
			begin
				check("cycles", 16'(prog[i].c), 16'(gap));
				check_res(i - 1);
			end
		end
		wait_done(gap);
		check_res(prog.size() - 1);
		repeat (2) @(negedge clk_sys);
		check("onchip reads", 16'h0001, 16'(mem.rd_cnt[0]));
		check("offchip writes", 16'h0001, 16'(mem.wr_cnt[1]));
		check("offchip reads", 16'h0001, 16'(mem.rd_cnt[1]));
		check("offchip data", 16'h005a, {8'h00, mem.dmem[1][16'h2000]});
		check("flash writes", 16'h0001, 16'(mem.wr_cnt[2]));
		check("flash data", 16'h0001, {8'h00, mem.dmem[2][16'h0300]});
		wrap_up();
	end
endmodule
